// ---- rtl/dac_mute_fuse_bias_regs.sv ----
// apb register bank: alarm muting, trim load status and bias settings
// Overview of operation
// - crc alarm mutes unless crc disable set
// - reference alarm mutes unless reference disable set
// - link mute clears on recovery or alarm clear
// - crc recovery 0 waits for alarm clear
// - crc recovery 1 unmutes when fault ends
// - trim done reads 1 only when idle
// - trim load ends before 523000 cycles
// - four-bit coarse bias per channel, reset F
// - six-bit fine bias, upper bits read zero
// - four-bit sleep coarse bias per channel
// - link loss alarm on link-up fall while receiver enabled
// - crc alarm on fault in 64b/66b
// - reference alarm on misaligned edge
// - alarm bits clear on write of one
`timescale 1ns/1ps
`default_nettype none
module dac_mute_fuse_bias_regs #(
  parameter int TRIM_LOAD_CYCLES = dac_mute_pkg::TRIM_LOAD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_up, // serial link up indication
  input wire logic crc_fault, // live crc fault, or of enabled lanes
  input wire logic ref_misalign_div, // misaligned edge seen by dividers
  input wire logic ref_misalign_rx, // misaligned edge seen by receiver
  output logic mute_ch0,
  output logic mute_ch1,
  output logic [5:0] fine_bias_ch0,
  output logic [5:0] fine_bias_ch1,
  output logic [3:0] coarse_bias_ch0,
  output logic [3:0] coarse_bias_ch1,
  output logic [3:0] sleep_bias_ch0,
  output logic [3:0] sleep_bias_ch1,
  output logic serial_rx_enable,
  output logic trim_done,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic {TRIM_LOAD, TRIM_IDLE} trim_state_t;
  typedef struct packed {
    logic [7:0] alarm; // sticky alarm flags
    logic [7:0] irq_stat; // sticky event copy for the interrupt
    logic [7:0] irq_en;
    logic [7:0] ctrl;
    logic [7:0] mute_dis;
    logic [7:0] mute_recovery_ctrl;
    logic [5:0] fine0;
    logic [5:0] fine1;
    logic [3:0] coarse0;
    logic [3:0] coarse1;
    logic [3:0] sleep0;
    logic [3:0] sleep1;
    trim_state_t trim_st;
    logic [19:0] trim_cnt;
    logic trim_done;
    logic link_up_q; // previous link_up for the fall detect
    logic link_mute;
    logic crc_mute;
    logic mute;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic slverr;
  } state_t;
  state_t s; // registered state
  state_t next_s; // next value
  logic [11:0] idx; // word index of the access
  logic acc; // access completes at this edge
  logic wr;
  logic rd;
  logic ev_link;
  logic ev_crc;
  logic ev_ref;
  logic [7:0] ev; // events in alarm layout
  logic [7:0] rdata;
  logic hit; // address is mapped
  logic [7:0] w1c; // alarm bits that software clears
  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // link_up_q starts at 0, so no fall is seen right after reset
  assign ev_link = s.link_up_q & ~link_up & s.ctrl[dac_mute_pkg::CTRL_RX_EN];
  assign ev_crc = crc_fault & s.ctrl[dac_mute_pkg::CTRL_CODING];
  // receiver view only counts while the receiver is enabled
  assign ev_ref = ref_misalign_div
                | (ref_misalign_rx & s.ctrl[dac_mute_pkg::CTRL_RX_EN]);
  // low two address bits are ignored: one register per word
  assign idx = paddr[13:2];
  // access completes on the cycle after the wait state, once ready is already high
  assign acc = psel & penable & s.pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    ev = 8'h00;
    ev[dac_mute_pkg::ALM_LINK] = ev_link;
    ev[dac_mute_pkg::ALM_CRC] = ev_crc;
    ev[dac_mute_pkg::ALM_REF] = ev_ref;
    // read decode, reserved bits read zero
    hit = 1'b1;
    unique case (idx)
      dac_mute_pkg::IDX_ALARM: rdata = s.alarm;
      dac_mute_pkg::IDX_MUTE_DIS: rdata = s.mute_dis;
      dac_mute_pkg::IDX_MUTE_RECOVERY_CTRL: rdata = s.mute_recovery_ctrl;
      dac_mute_pkg::IDX_TRIM: rdata = {7'h00, s.trim_done};
      dac_mute_pkg::IDX_FINE0: rdata = {2'h0, s.fine0};
      dac_mute_pkg::IDX_FINE1: rdata = {2'h0, s.fine1};
      dac_mute_pkg::IDX_COARSE0: rdata = {s.sleep0, s.coarse0};
      dac_mute_pkg::IDX_COARSE1: rdata = {s.sleep1, s.coarse1};
      dac_mute_pkg::IDX_IRQ_STAT: rdata = s.irq_stat;
      dac_mute_pkg::IDX_IRQ_EN: rdata = s.irq_en;
      dac_mute_pkg::IDX_CTRL: rdata = s.ctrl;
      default: begin
        rdata = 8'h00; // unmapped reads zero with an error
        hit = 1'b0;
      end
    endcase
    // one wait state: data and ready come from flops
    next_s.pready = psel & penable & ~s.pready;
    next_s.slverr = 1'b0;
    if (next_s.pready) begin
      next_s.prdata = {24'h000000, rdata};
      next_s.slverr = ~hit;
    end
    // alarms: write 1 clears, a new event in the same cycle wins
    w1c = 8'h00;
    if (wr && idx == dac_mute_pkg::IDX_ALARM) begin
      w1c = pwdata[7:0];
    end
    next_s.alarm = ((s.alarm & ~w1c) | ev) & dac_mute_pkg::ALARM_BITS;
    // interrupt status clears on read, set still wins
    if (rd && idx == dac_mute_pkg::IDX_IRQ_STAT) begin
      next_s.irq_stat = ev;
    end else begin
      next_s.irq_stat = s.irq_stat | ev;
    end
    // register writes
    if (wr) begin
      unique case (idx)
        dac_mute_pkg::IDX_MUTE_DIS: next_s.mute_dis = pwdata[7:0];
        dac_mute_pkg::IDX_MUTE_RECOVERY_CTRL: next_s.mute_recovery_ctrl = pwdata[7:0];
        dac_mute_pkg::IDX_FINE0: next_s.fine0 = pwdata[5:0];
        dac_mute_pkg::IDX_FINE1: next_s.fine1 = pwdata[5:0];
        dac_mute_pkg::IDX_COARSE0: begin
          next_s.coarse0 = pwdata[3:0];
          next_s.sleep0 = pwdata[7:4];
        end
        dac_mute_pkg::IDX_COARSE1: begin
          next_s.coarse1 = pwdata[3:0];
          next_s.sleep1 = pwdata[7:4];
        end
        dac_mute_pkg::IDX_IRQ_EN: next_s.irq_en = pwdata[7:0];
        dac_mute_pkg::IDX_CTRL: next_s.ctrl = pwdata[7:0] & dac_mute_pkg::CTRL_BITS;
        default: begin
          next_s.ctrl = s.ctrl; // read-only and unmapped writes ignored
        end
      endcase
    end
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
    // trim load sequencer: counts from reset release, then idles
    // no access guard during the load: software must see trim_done first
    unique case (s.trim_st)
      TRIM_LOAD: begin
        next_s.trim_cnt = s.trim_cnt + 20'h00001;
        if (s.trim_cnt == 20'(TRIM_LOAD_CYCLES - 1)) begin
          next_s.trim_st = TRIM_IDLE;
          next_s.trim_done = 1'b1;
        end
      end
      TRIM_IDLE: begin
        next_s.trim_done = 1'b1;
      end
    endcase
    next_s.link_up_q = link_up;
    // link loss mute: recovery chosen by the auto-unmute bit
    // alarm-clear recovery is judged on the registered alarm, so that release lags one cycle; auto recovery uses live link_up
    if (ev_link) begin
      next_s.link_mute = 1'b1;
    end else if (s.link_mute) begin
      if (s.mute_recovery_ctrl[dac_mute_pkg::REC_LINK]) begin
        next_s.link_mute = ~link_up;
      end else begin
        next_s.link_mute = s.alarm[dac_mute_pkg::ALM_LINK];
      end
    end
    // crc mute: disabled outright, or held per crc recovery bit
    if (s.mute_dis[dac_mute_pkg::DIS_CRC]) begin
      next_s.crc_mute = 1'b0;
    end else if (ev_crc) begin
      next_s.crc_mute = 1'b1;
    end else if (s.crc_mute) begin
      if (s.mute_recovery_ctrl[dac_mute_pkg::REC_CRC]) begin
        next_s.crc_mute = crc_fault;
      end else begin
        next_s.crc_mute = s.alarm[dac_mute_pkg::ALM_CRC];
      end
    end
    // reference mute follows the alarm itself while not disabled
    next_s.mute = next_s.link_mute | next_s.crc_mute
                | (next_s.alarm[dac_mute_pkg::ALM_REF]
                   & ~next_s.mute_dis[dac_mute_pkg::DIS_REF]);
  end
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mute_dis <= dac_mute_pkg::MUTE_DIS_RST;
      s.mute_recovery_ctrl <= dac_mute_pkg::MUTE_RECOVERY_CTRL_RST;
      s.ctrl <= dac_mute_pkg::CTRL_RST;
      s.irq_en <= dac_mute_pkg::IRQ_EN_RST;
      // trim-backed bias fields start from plain defaults
      s.fine0 <= dac_mute_pkg::FINE_RST;
      s.fine1 <= dac_mute_pkg::FINE_RST;
      s.coarse0 <= dac_mute_pkg::COARSE_RST;
      s.coarse1 <= dac_mute_pkg::COARSE_RST;
      s.sleep0 <= dac_mute_pkg::SLEEP_RST;
      s.sleep1 <= dac_mute_pkg::SLEEP_RST;
      s.trim_st <= TRIM_LOAD;
    end else begin
      s <= next_s;
    end
  end
  // outputs straight from flops
  // both channels share one mute: any alarm whose mute is not disabled silences the pair
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.slverr;
  assign mute_ch0 = s.mute;
  assign mute_ch1 = s.mute;
  assign fine_bias_ch0 = s.fine0;
  assign fine_bias_ch1 = s.fine1;
  assign coarse_bias_ch0 = s.coarse0;
  assign coarse_bias_ch1 = s.coarse1;
  assign sleep_bias_ch0 = s.sleep0;
  assign sleep_bias_ch1 = s.sleep1;
  assign serial_rx_enable = s.ctrl[dac_mute_pkg::CTRL_RX_EN];
  assign trim_done = s.trim_done;
  assign irq = s.irq;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // named steps of a register access, shared by the properties
  sequence seq_setup_rd(logic [11:0] i);
    psel && penable && !s.pready && !pwrite && idx == i;
  endsequence
  sequence seq_wr(logic [11:0] i);
    wr && idx == i;
  endsequence
  // properties read the registered state, so each |=> check lags its cause by one edge
  a_crc_mute_set: assert property (ev_crc && !s.mute_dis[5]
    |=> s.crc_mute && s.mute) else $error("crc event did not mute");
  a_ref_mute_on: assert property (s.alarm[0] && !s.mute_dis[0] |-> s.mute)
    else $error("reference alarm not muting");
  a_link_auto_rel: assert property (s.link_mute && s.mute_recovery_ctrl[7] && link_up
    |=> !s.link_mute) else $error("link mute not auto released");
  a_link_hold_mute: assert property (s.link_mute && !s.mute_recovery_ctrl[7] && s.alarm[7]
    |=> s.link_mute) else $error("link mute dropped early");
  a_crc_hold_mute: assert property (s.crc_mute && !s.mute_dis[5] && !s.mute_recovery_ctrl[5]
    && s.alarm[5] |=> s.crc_mute) else $error("crc mute dropped early");
  a_crc_auto_rel: assert property (s.crc_mute && s.mute_recovery_ctrl[5] && !crc_fault
    |=> !s.crc_mute) else $error("crc mute not auto released");
  a_trim_done_stays: assert property (s.trim_done
    |=> s.trim_done && s.trim_st == TRIM_IDLE) else $error("trim done fell");
  a_trim_load_bound: assert property (!s.trim_done
    |-> s.trim_cnt < 20'(TRIM_LOAD_CYCLES)) else $error("trim load too long");
  a_coarse_write: assert property (seq_wr(dac_mute_pkg::IDX_COARSE0)
    |=> s.coarse0 == $past(pwdata[3:0])) else $error("coarse bias not written");
  a_fine_rsvd_zero: assert property (seq_setup_rd(dac_mute_pkg::IDX_FINE1)
    |=> s.prdata[7:6] == 2'b00 && s.pready) else $error("fine reserved not zero");
  a_sleep_write: assert property (seq_wr(dac_mute_pkg::IDX_COARSE1)
    |=> s.sleep1 == $past(pwdata[7:4])) else $error("sleep bias not written");
  a_mute_release: assert property (s.mute |-> s.link_mute || s.crc_mute || s.alarm[0])
    else $error("mute without cause");
  a_link_alarm_set: assert property (ev_link
    |=> s.alarm[7] ##1 s.alarm[7] || $past(wr)) else $error("link alarm not set");
  a_crc_alarm_set: assert property (crc_fault && s.ctrl[1] |=> s.alarm[5])
    else $error("crc alarm not set");
  a_ref_alarm_set: assert property (ref_misalign_div |=> s.alarm[0])
    else $error("reference alarm not set");
  a_alarm_w1c: assert property (wr && idx == dac_mute_pkg::IDX_ALARM && pwdata[7]
    && !ev_link |=> !s.alarm[7]) else $error("alarm not cleared");
endmodule
`default_nettype wire

// ---- rtl/dac_mute_pkg.sv ----
// constants for the mute, trim status and bias register bank
package dac_mute_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_ALARM = 12'h430; // alarm flags, write 1 clears
  localparam logic [11:0] IDX_MUTE_DIS = 12'h432; // alarm_mute_disable
  localparam logic [11:0] IDX_MUTE_RECOVERY_CTRL = 12'h433; // mute_recovery_ctrl
  localparam logic [11:0] IDX_TRIM = 12'h600; // trim_load_status
  localparam logic [11:0] IDX_FINE0 = 12'h723;
  localparam logic [11:0] IDX_COARSE0 = 12'h724;
  localparam logic [11:0] IDX_FINE1 = 12'h725;
  localparam logic [11:0] IDX_COARSE1 = 12'h726;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h7F0; // sticky events, read clears
  localparam logic [11:0] IDX_IRQ_EN = 12'h7F1; // 1 lets a status bit reach irq
  localparam logic [11:0] IDX_CTRL = 12'h7F2; // receiver enable, line coding
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ALM_LINK = 7;
  localparam int ALM_CRC = 5;
  localparam int ALM_REF = 0;
  localparam int DIS_CRC = 5;
  localparam int DIS_REF = 0;
  localparam int REC_LINK = 7;
  localparam int REC_CRC = 5;
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_CODING = 1; // 1 selects 64b/66b line coding
  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] ALARM_BITS = 8'hA1; // implemented alarm bits
  localparam logic [7:0] CTRL_BITS = 8'h03;
  localparam logic [7:0] MUTE_DIS_RST = 8'h21;
  localparam logic [7:0] MUTE_RECOVERY_CTRL_RST = 8'hA0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [3:0] COARSE_RST = 4'hF;
  localparam logic [3:0] SLEEP_RST = 4'h0;
  localparam logic [5:0] FINE_RST = 6'h20; // per-device value, plain default
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TRIM_LOAD_MAX_CYC = 523000; // bound on the load, in clk cycles
  localparam int TRIM_LOAD_CYC = TRIM_LOAD_MAX_CYC - 1; // fewer than the bound
endpackage

// ---- test/tb.sv ----
// self-checking bench for the mute, trim status and bias register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  localparam int TRIM_CYC = 20; // short trim load keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic link_up = 1'b0;
  logic crc_fault = 1'b0;
  logic ref_misalign_div = 1'b0;
  logic ref_misalign_rx = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, mute_ch0, mute_ch1, serial_rx_enable, trim_done, irq;
  logic [5:0] fine_bias_ch0, fine_bias_ch1;
  logic [3:0] coarse_bias_ch0, coarse_bias_ch1, sleep_bias_ch0, sleep_bias_ch1;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0; // edges since reset release
  logic [31:0] q;
  logic e;
  // clock, 8 ns period
  always #4 pclk = ~pclk;
  // count edges after release for the trim bound
  always @(posedge pclk) begin
    if (presetn) begin
      cyc <= cyc + 1;
    end
  end
  dac_mute_fuse_bias_regs #(.TRIM_LOAD_CYCLES(TRIM_CYC)) dac_mute_fuse_bias_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .crc_fault(crc_fault), .ref_misalign_div(ref_misalign_div),
    .ref_misalign_rx(ref_misalign_rx), .mute_ch0(mute_ch0), .mute_ch1(mute_ch1),
    .fine_bias_ch0(fine_bias_ch0), .fine_bias_ch1(fine_bias_ch1),
    .coarse_bias_ch0(coarse_bias_ch0), .coarse_bias_ch1(coarse_bias_ch1),
    .sleep_bias_ch0(sleep_bias_ch0), .sleep_bias_ch1(sleep_bias_ch1),
    .serial_rx_enable(serial_rx_enable), .trim_done(trim_done), .irq(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict and end of run, shared with the watchdog
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // value compare, case inequality so x never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++; // no answer counts as a mismatch
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(q, {24'h000000, exp});
  endtask
  // wait a bounded time for mute_ch0 to reach a level, then check both mutes
  task automatic waitm(input logic exp);
    int n;
    n = 0;
    while (mute_ch0 !== exp && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk({30'h0, mute_ch1, mute_ch0}, {30'h0, exp, exp});
  endtask
  // one-cycle misaligned reference edge from the dividers
  task automatic ref_pulse;
    @(posedge pclk);
    ref_misalign_div <= 1'b1;
    @(posedge pclk);
    ref_misalign_div <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // watchdog: the tests need a few hundred cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(dac_mute_pkg::IDX_TRIM, 8'h00);
    while (trim_done !== 1'b1 && cyc < TRIM_CYC + 4) @(posedge pclk);
    chk(32'(cyc <= TRIM_CYC + 1), 32'h1);
    rd(dac_mute_pkg::IDX_TRIM, 8'h01);
    wr(dac_mute_pkg::IDX_TRIM, 8'h00);
    rd(dac_mute_pkg::IDX_TRIM, 8'h01);
    // reset values, trim-backed ones only after the load
    rd(dac_mute_pkg::IDX_MUTE_DIS, 8'h21);
    rd(dac_mute_pkg::IDX_MUTE_RECOVERY_CTRL, 8'hA0);
    rd(dac_mute_pkg::IDX_COARSE0, 8'h0F);
    rd(dac_mute_pkg::IDX_COARSE1, 8'h0F);
    rd(dac_mute_pkg::IDX_FINE0, 8'h20);
    // bias fields: width, reserved bits, port values
    wr(dac_mute_pkg::IDX_FINE0, 8'hFF);
    rd(dac_mute_pkg::IDX_FINE0, 8'h3F);
    wr(dac_mute_pkg::IDX_FINE1, 8'hD5);
    rd(dac_mute_pkg::IDX_FINE1, 8'h15);
    wr(dac_mute_pkg::IDX_COARSE0, 8'hA5);
    rd(dac_mute_pkg::IDX_COARSE0, 8'hA5);
    wr(dac_mute_pkg::IDX_COARSE1, 8'h3C);
    @(posedge pclk); // ports update at the completing edge, look one edge later
    chk({8'h00, 2'b00, fine_bias_ch0, 2'b00, fine_bias_ch1, 4'h0, coarse_bias_ch0},
      32'h003F1505);
    chk({16'h0, sleep_bias_ch0, sleep_bias_ch1, coarse_bias_ch1, 4'h0}, 32'h0000A3C0);
    // unmapped index refuses with an error
    apb(1'b0, 12'h7FF, 8'h00);
    chk({q[30:0], e}, 32'h00000001);
    // receiver on, 64b/66b coding, all irq sources enabled
    wr(dac_mute_pkg::IDX_CTRL, 8'h03);
    wr(dac_mute_pkg::IDX_IRQ_EN, 8'hA1);
    chk(32'(serial_rx_enable), 32'h1);
    // reference alarm while its mute is disabled
    ref_pulse();
    repeat (3) @(posedge pclk);
    chk({30'h0, irq, mute_ch0}, 32'h2);
    rd(dac_mute_pkg::IDX_ALARM, 8'h01);
    rd(dac_mute_pkg::IDX_IRQ_STAT, 8'h01);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    wr(dac_mute_pkg::IDX_ALARM, 8'h01);
    rd(dac_mute_pkg::IDX_ALARM, 8'h00);
    // receiver view of the reference counts while the receiver is on
    @(posedge pclk) ref_misalign_rx <= 1'b1;
    @(posedge pclk) ref_misalign_rx <= 1'b0;
    rd(dac_mute_pkg::IDX_ALARM, 8'h01);
    wr(dac_mute_pkg::IDX_ALARM, 8'h01);
    // masked interrupt: status sets, irq stays low
    wr(dac_mute_pkg::IDX_IRQ_EN, 8'h00);
    wr(dac_mute_pkg::IDX_MUTE_DIS, 8'h00);
    ref_pulse();
    waitm(1'b1);
    chk(32'(irq), 32'h0);
    rd(dac_mute_pkg::IDX_IRQ_STAT, 8'h01);
    wr(dac_mute_pkg::IDX_ALARM, 8'h00);
    rd(dac_mute_pkg::IDX_ALARM, 8'h01);
    chk(32'(mute_ch0), 32'h1);
    wr(dac_mute_pkg::IDX_ALARM, 8'h01);
    waitm(1'b0);
    // crc with auto unmute: clears as soon as the fault ends
    @(posedge pclk) crc_fault <= 1'b1;
    waitm(1'b1);
    @(posedge pclk) crc_fault <= 1'b0;
    waitm(1'b0);
    rd(dac_mute_pkg::IDX_ALARM, 8'h20);
    wr(dac_mute_pkg::IDX_ALARM, 8'h20);
    // crc without auto unmute: waits for the alarm clear
    wr(dac_mute_pkg::IDX_MUTE_RECOVERY_CTRL, 8'h80);
    @(posedge pclk) crc_fault <= 1'b1;
    @(posedge pclk) crc_fault <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(mute_ch1), 32'h1);
    wr(dac_mute_pkg::IDX_ALARM, 8'h20);
    waitm(1'b0);
    // crc mute disabled: alarm sets, outputs stay live
    wr(dac_mute_pkg::IDX_MUTE_DIS, 8'h20);
    @(posedge pclk) crc_fault <= 1'b1;
    @(posedge pclk) crc_fault <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(mute_ch0), 32'h0);
    rd(dac_mute_pkg::IDX_ALARM, 8'h20);
    wr(dac_mute_pkg::IDX_ALARM, 8'h20);
    // link loss with auto unmute (recovery bits now 0x80)
    @(posedge pclk) link_up <= 1'b1;
    @(posedge pclk) link_up <= 1'b0;
    waitm(1'b1);
    rd(dac_mute_pkg::IDX_ALARM, 8'h80);
    @(posedge pclk) link_up <= 1'b1;
    waitm(1'b0);
    wr(dac_mute_pkg::IDX_ALARM, 8'h80);
    // link loss without auto unmute: held until alarm clear
    wr(dac_mute_pkg::IDX_MUTE_RECOVERY_CTRL, 8'h00);
    @(posedge pclk) link_up <= 1'b0;
    waitm(1'b1);
    @(posedge pclk) link_up <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(mute_ch0), 32'h1);
    wr(dac_mute_pkg::IDX_ALARM, 8'h80);
    waitm(1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
